// ==== sfs_pkg.sv ====
// shared constants and types for the serial flash spi front end
package sfs_pkg;
    // command codes
    localparam logic [7:0] CMD_WR_EN      = 8'h06;
    localparam logic [7:0] CMD_WR_DIS     = 8'h04;
    localparam logic [7:0] CMD_RD_STATUS  = 8'h05;
    localparam logic [7:0] CMD_WR_STATUS  = 8'h01;
    localparam logic [7:0] CMD_RD_DATA    = 8'h03;
    localparam logic [7:0] CMD_RD_FAST    = 8'h0B;
    localparam logic [7:0] CMD_RD_DUAL    = 8'h3B;
    localparam logic [7:0] CMD_PROG_PAGE  = 8'h02;
    localparam logic [7:0] CMD_ERASE_SECT = 8'h20;
    localparam logic [7:0] CMD_ERASE_B32  = 8'h52;
    localparam logic [7:0] CMD_ERASE_B64  = 8'hD8;
    localparam logic [7:0] CMD_ERASE_ALL  = 8'h60;
    localparam logic [7:0] CMD_ERASE_ALL2 = 8'hC7;
    // memory organisation
    localparam int PAGE_BYTES  = 256;
    localparam int SECT_BYTES  = 4096;
    localparam int SECT_SHIFT  = 12;
    localparam int BLK32_BYTES = 32768;
    localparam int BLK64_BYTES = 65536;
    localparam int CAP_LARGE   = 131072;
    localparam int CAP_SMALL   = 65536;
    localparam int ADDR_W      = 24;
    // serial framing
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [2:0] DUAL_LAST = 3'h3;
    localparam logic [1:0] ADDR_LAST = 2'h2;
    // status byte fields
    localparam int ST_SRP  = 7;
    localparam int ST_BP_H = 4;
    localparam int ST_BP_L = 2;
    localparam int ST_WEL  = 1;
    localparam int ST_WIP  = 0;
    // request word: op | address | data
    localparam int REQ_W      = 36;
    localparam int REQ_OP_L   = 32;
    localparam int REQ_ADDR_L = 8;
    typedef enum logic [3:0] {
        OP_PROG       = 4'h1,
        OP_ERASE_SECT = 4'h2,
        OP_ERASE_B32  = 4'h3,
        OP_ERASE_B64  = 4'h4,
        OP_ERASE_ALL  = 4'h5
    } sfs_op_type;
    typedef enum logic [2:0] {
        ST_CMD   = 3'b000,
        ST_ADDR  = 3'b001,
        ST_DUMMY = 3'b010,
        ST_RDATA = 3'b011,
        ST_WDATA = 3'b100,
        ST_SKIP  = 3'b101
    } sfs_state_type;
endpackage

// ==== sfs_stream_if.sv ====
// valid/ready word channel between the front end and its fifo
`timescale 1ns/1ps
interface sfs_stream_if #(parameter int W = 36);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== sfs_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module sfs_fifo #(
    parameter int W     = 36,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic   sys_clk_i,
    input  wire logic   resetn_i,
    // fill and drain sides
    sfs_stream_if.snk   in_s,
    sfs_stream_if.src   out_s
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_s.ready  = (cnt_r != CNT_FULL);
    assign out_s.valid = (cnt_r != '0);
    assign out_s.data  = mem_r[rd_ptr_r];
    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_s.data;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// ==== sfs_addr_map.sv ====
// address decode: region bases and block-protect check
`timescale 1ns/1ps
module sfs_addr_map import sfs_pkg::*; #(
    parameter int CAP_BYTES = CAP_LARGE
) (
    // address and protect level
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [2:0]        bp_i,
    // decode results
    output logic                   prot_o,
    output logic [ADDR_W-1:0]      sect_base_o,
    output logic [ADDR_W-1:0]      b32_base_o,
    output logic [ADDR_W-1:0]      b64_base_o
);
    localparam int SECTS = CAP_BYTES / SECT_BYTES;
    localparam logic [ADDR_W-1:0] CAP_MASK = ADDR_W'(CAP_BYTES - 1);
    localparam logic [11:0] LIM_ALL = 12'(SECTS);

    logic [ADDR_W-1:0] a;
    logic [11:0]       lim;

    assign a           = addr_i & CAP_MASK;
    assign sect_base_o = a & ~ADDR_W'(SECT_BYTES - 1);
    assign b32_base_o  = a & ~ADDR_W'(BLK32_BYTES - 1);
    assign b64_base_o  = a & ~ADDR_W'(BLK64_BYTES - 1);

    // protected area is always the lower sectors
    always_comb begin
        unique case (bp_i)
            3'h0:    lim = '0;
            3'h1:    lim = 12'(SECTS - SECTS / 16);
            3'h2:    lim = 12'(SECTS - SECTS / 8);
            3'h3:    lim = 12'(SECTS - SECTS / 4);
            3'h4:    lim = (SECTS > 16) ? 12'(SECTS / 2) : LIM_ALL;
            default: lim = LIM_ALL;
        endcase
    end

    assign prot_o = (a[ADDR_W-1:SECT_SHIFT] < lim);
endmodule

// ==== sfs_spi_top.sv ====
// serial flash spi front end: pin sampling, command decode, request fifo
`timescale 1ns/1ps
module sfs_spi_top import sfs_pkg::*; #(
    parameter int CAP_BYTES  = CAP_LARGE,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              resetn_i,
    // serial pins
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              wp_n_i,
    input  wire logic              dual_lane_zero_i,
    output logic                   dual_lane_zero_o,
    output logic                   dual_lane_zero_oe_n_o,
    output logic                   dual_lane_one_o,
    output logic                   dual_lane_one_oe_n_o,
    // array read port
    output logic [ADDR_W-1:0]      rd_addr_o,
    input  wire logic [7:0]        rd_data_i,
    input  wire logic              wip_i,
    // array write/erase requests
    output logic                   req_valid_o,
    input  wire logic              req_ready_i,
    output logic [3:0]             req_op_o,
    output logic [ADDR_W-1:0]      req_addr_o,
    output logic [7:0]             req_data_o,
    // status
    output logic                   wel_o,
    output logic                   srp_o,
    output logic [2:0]             block_protect_bits_o,
    output logic                   overrun_o
);
    localparam logic [ADDR_W-1:0] CAP_MASK = ADDR_W'(CAP_BYTES - 1);

    // pin synchronisers
    logic [2:0]        sclk_sync_r;
    logic [2:0]        cs_sync_r;
    logic [1:0]        din_sync_r;
    logic [1:0]        wp_sync_r;
    logic              rise;
    logic              fall;
    logic              sel;
    logic              desel_edge;
    logic              din;
    logic              wp_low;
    // shift engine
    sfs_state_type     state_r;
    logic [2:0]        bit_cnt_r;
    logic [1:0]        addr_cnt_r;
    logic [6:0]        rx_sh_r;
    logic [7:0]        cmd_r;
    logic [ADDR_W-1:0] addr_r;
    logic [7:0]        st_byte_r;
    logic              dual_r;
    logic [7:0]        byte_in;
    logic              last_bit;
    logic              byte_done;
    logic              start_rd;
    // output lanes
    logic [7:0]        tx_sh_r;
    logic              load_pend_r;
    logic              out0_r;
    logic              out1_r;
    logic              oe0_n_r;
    logic              oe1_n_r;
    logic [7:0]        tx_src;
    logic [7:0]        status;
    // control bits
    logic              wel_r;
    logic              srp_r;
    logic [2:0]        bp_r;
    logic              overrun_r;
    logic              frame_ok;
    logic              pp_end;
    // decode and requests
    logic              prot;
    logic [ADDR_W-1:0] sect_base;
    logic [ADDR_W-1:0] b32_base;
    logic [ADDR_W-1:0] b64_base;
    logic              push_valid;
    logic [3:0]        push_op;
    logic [ADDR_W-1:0] push_addr;
    logic              req_valid_r;
    logic [3:0]        req_op_r;
    logic [ADDR_W-1:0] req_addr_r;
    logic [7:0]        req_data_r;

    sfs_stream_if #(.W(REQ_W)) push_if ();
    sfs_stream_if #(.W(REQ_W)) pop_if ();

    // chip select idles high; write-protect idles high until sampled
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            sclk_sync_r <= '0;
            cs_sync_r   <= '1;
            din_sync_r  <= '0;
            wp_sync_r   <= '1;
        end else begin
            sclk_sync_r <= {sclk_sync_r[1:0], sclk_i};
            cs_sync_r   <= {cs_sync_r[1:0], cs_n_i};
            din_sync_r  <= {din_sync_r[0], dual_lane_zero_i};
            wp_sync_r   <= {wp_sync_r[0], wp_n_i};
        end
    end

    // edges only; the idle level of the clock is irrelevant
    assign rise       = sclk_sync_r[1] & ~sclk_sync_r[2];
    assign fall       = ~sclk_sync_r[1] & sclk_sync_r[2];
    assign sel        = ~cs_sync_r[1];
    assign desel_edge = cs_sync_r[1] & ~cs_sync_r[2];
    assign din        = din_sync_r[1];
    assign wp_low     = ~wp_sync_r[1];

    assign byte_in   = {rx_sh_r, din};
    assign last_bit  = (state_r == ST_RDATA && dual_r) ? (bit_cnt_r == DUAL_LAST)
                                                      : (bit_cnt_r == BYTE_LAST);
    assign byte_done = sel & rise & last_bit;

    // bit receiver, msb first
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || !sel) begin
            bit_cnt_r <= '0;
            rx_sh_r   <= '0;
        end else if (rise) begin
            rx_sh_r   <= byte_in[6:0];
            bit_cnt_r <= last_bit ? '0 : bit_cnt_r + 1'b1;
        end
    end

    // command sequencer
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state_r    <= ST_CMD;
            cmd_r      <= '0;
            addr_cnt_r <= '0;
            addr_r     <= '0;
            st_byte_r  <= '0;
            dual_r     <= 1'b0;
        end else if (!sel) begin
            state_r <= ST_CMD;
            dual_r  <= 1'b0;
        end else if (byte_done) begin
            unique case (state_r)
                ST_CMD: begin
                    cmd_r      <= byte_in;
                    addr_cnt_r <= '0;
                    unique case (byte_in)
                        CMD_RD_DATA, CMD_RD_FAST, CMD_RD_DUAL, CMD_PROG_PAGE,
                        CMD_ERASE_SECT, CMD_ERASE_B32, CMD_ERASE_B64:
                            state_r <= ST_ADDR;
                        CMD_RD_STATUS: state_r <= ST_RDATA;
                        CMD_WR_STATUS: state_r <= ST_WDATA;
                        default:       state_r <= ST_SKIP;
                    endcase
                end
                ST_ADDR: begin
                    addr_r     <= {addr_r[ADDR_W-9:0], byte_in};
                    addr_cnt_r <= addr_cnt_r + 1'b1;
                    if (addr_cnt_r == ADDR_LAST) begin
                        unique case (cmd_r)
                            CMD_RD_DATA:               state_r <= ST_RDATA;
                            CMD_RD_FAST, CMD_RD_DUAL:  state_r <= ST_DUMMY;
                            CMD_PROG_PAGE:             state_r <= ST_WDATA;
                            default:                   state_r <= ST_SKIP;
                        endcase
                    end
                end
                ST_DUMMY: begin
                    state_r <= ST_RDATA;
                    dual_r  <= (cmd_r == CMD_RD_DUAL);
                end
                ST_RDATA: begin
                    addr_r <= (addr_r + 1'b1) & CAP_MASK;
                end
                ST_WDATA: begin
                    if (cmd_r == CMD_PROG_PAGE) begin
                        addr_r[7:0] <= addr_r[7:0] + 1'b1;
                    end else begin
                        st_byte_r <= byte_in;
                        state_r   <= ST_SKIP;
                    end
                end
                default: state_r <= ST_SKIP;
            endcase
        end
    end

    assign rd_addr_o = addr_r;

    always_comb begin
        status          = '0;
        status[ST_SRP]  = srp_r;
        status[ST_BP_H:ST_BP_L] = bp_r;
        status[ST_WEL]  = wel_r;
        status[ST_WIP]  = wip_i;
    end

    assign start_rd = byte_done &&
        ((state_r == ST_CMD && byte_in == CMD_RD_STATUS) ||
         (state_r == ST_ADDR && addr_cnt_r == ADDR_LAST && cmd_r == CMD_RD_DATA) ||
         state_r == ST_DUMMY || state_r == ST_RDATA);

    // new byte fetched at the fall so the array has half a clock to answer
    assign tx_src = !load_pend_r ? tx_sh_r :
                    (cmd_r == CMD_RD_STATUS) ? status : rd_data_i;

    // output lanes change on falling edges and return to idle on deselect
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || !sel) begin
            load_pend_r <= 1'b0;
            tx_sh_r     <= '0;
            out0_r      <= 1'b0;
            out1_r      <= 1'b0;
            oe0_n_r     <= 1'b1;
            oe1_n_r     <= 1'b1;
        end else begin
            if (start_rd) begin
                load_pend_r <= 1'b1;
            end
            if (fall && (load_pend_r || !oe1_n_r)) begin
                load_pend_r <= 1'b0;
                oe1_n_r     <= 1'b0;
                out1_r      <= tx_src[7];
                if (dual_r) begin
                    out0_r  <= tx_src[6];
                    oe0_n_r <= 1'b0;
                    tx_sh_r <= {tx_src[5:0], 2'b00};
                end else begin
                    tx_sh_r <= {tx_src[6:0], 1'b0};
                end
            end
        end
    end

    assign dual_lane_zero_o      = out0_r;
    assign dual_lane_zero_oe_n_o = oe0_n_r;
    assign dual_lane_one_o       = out1_r;
    assign dual_lane_one_oe_n_o  = oe1_n_r;

    sfs_addr_map #(.CAP_BYTES(CAP_BYTES)) u_map (
        .addr_i      (addr_r),
        .bp_i        (bp_r),
        .prot_o      (prot),
        .sect_base_o (sect_base),
        .b32_base_o  (b32_base),
        .b64_base_o  (b64_base)
    );

    // commands without data run only if the frame ends on a byte boundary
    assign frame_ok = desel_edge && state_r == ST_SKIP && bit_cnt_r == '0;
    assign pp_end   = desel_edge && state_r == ST_WDATA && bit_cnt_r == '0 &&
                      cmd_r == CMD_PROG_PAGE;

    always_comb begin
        push_valid = 1'b0;
        push_op    = OP_PROG;
        push_addr  = addr_r & CAP_MASK;
        if (byte_done && state_r == ST_WDATA && cmd_r == CMD_PROG_PAGE) begin
            push_valid = wel_r && !prot;
        end else if (frame_ok && wel_r) begin
            unique case (cmd_r)
                CMD_ERASE_SECT: begin
                    push_valid = !prot;
                    push_op    = OP_ERASE_SECT;
                    push_addr  = sect_base;
                end
                CMD_ERASE_B32: begin
                    push_valid = !prot;
                    push_op    = OP_ERASE_B32;
                    push_addr  = b32_base;
                end
                CMD_ERASE_B64: begin
                    push_valid = !prot;
                    push_op    = OP_ERASE_B64;
                    push_addr  = b64_base;
                end
                CMD_ERASE_ALL, CMD_ERASE_ALL2: begin
                    push_valid = (bp_r == '0);
                    push_op    = OP_ERASE_ALL;
                    push_addr  = '0;
                end
                default: push_valid = 1'b0;
            endcase
        end
    end

    assign push_if.valid = push_valid;
    assign push_if.data  = {push_op, push_addr, byte_in};

    // write-enable latch and status bits
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            wel_r     <= 1'b0;
            srp_r     <= 1'b0;
            bp_r      <= '0;
            overrun_r <= 1'b0;
        end else begin
            if (push_valid && !push_if.ready) begin
                overrun_r <= 1'b1;
            end
            if (pp_end) begin
                wel_r <= 1'b0;
            end else if (frame_ok) begin
                unique case (cmd_r)
                    CMD_WR_EN:  wel_r <= 1'b1;
                    CMD_WR_DIS: wel_r <= 1'b0;
                    CMD_WR_STATUS: begin
                        wel_r <= 1'b0;
                        if (wel_r && !(srp_r && wp_low)) begin
                            srp_r <= st_byte_r[ST_SRP];
                            bp_r  <= st_byte_r[ST_BP_H:ST_BP_L];
                        end
                    end
                    CMD_ERASE_SECT, CMD_ERASE_B32, CMD_ERASE_B64,
                    CMD_ERASE_ALL, CMD_ERASE_ALL2:
                        wel_r <= 1'b0;
                    default: wel_r <= wel_r;
                endcase
            end
        end
    end

    sfs_fifo #(.W(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .in_s      (push_if.snk),
        .out_s     (pop_if.src)
    );

    // registered request output stage
    assign pop_if.ready = !req_valid_r || req_ready_i;

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            req_valid_r <= 1'b0;
            req_op_r    <= '0;
            req_addr_r  <= '0;
            req_data_r  <= '0;
        end else if (pop_if.ready) begin
            req_valid_r <= pop_if.valid;
            if (pop_if.valid) begin
                req_op_r   <= pop_if.data[REQ_W-1:REQ_OP_L];
                req_addr_r <= pop_if.data[REQ_OP_L-1:REQ_ADDR_L];
                req_data_r <= pop_if.data[REQ_ADDR_L-1:0];
            end
        end
    end

    assign req_valid_o          = req_valid_r;
    assign req_op_o             = req_op_r;
    assign req_addr_o           = req_addr_r;
    assign req_data_o           = req_data_r;
    assign wel_o                = wel_r;
    assign srp_o                = srp_r;
    assign block_protect_bits_o = bp_r;
    assign overrun_o            = overrun_r;
endmodule

// ==== sfs_spi_sva.sv ====
// pin-level assertions for the serial flash spi front end
`timescale 1ns/1ps
module sfs_spi_sva import sfs_pkg::*; #(
    parameter int CAP_BYTES = CAP_LARGE
) (
    // clock, reset and pins
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire logic        sclk_i,
    input wire logic        cs_n_i,
    input wire logic        wp_n_i,
    // outputs watched
    input wire logic        dual_lane_one_o,
    input wire logic        dual_lane_zero_oe_n_o,
    input wire logic        dual_lane_one_oe_n_o,
    input wire logic        req_valid_o,
    input wire logic [3:0]  req_op_o,
    input wire logic [23:0] req_addr_o,
    input wire logic        srp_o,
    input wire logic [2:0]  block_protect_bits_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence cs_idle;
        cs_n_i [*5];
    endsequence
    sequence wp_held;
        (!wp_n_i) [*4] ##0 srp_o;
    endsequence
    a_lanes_idle: assert property (cs_idle |->
        dual_lane_zero_oe_n_o && dual_lane_one_oe_n_o) else $error("lane driven while idle");
    a_dual_pair: assert property (!dual_lane_zero_oe_n_o |->
        !dual_lane_one_oe_n_o) else $error("lane zero driven alone");
    a_shift_fall: assert property ($changed(dual_lane_one_o) && !dual_lane_one_oe_n_o
        && !$past(dual_lane_one_oe_n_o) |-> !$past(sclk_i)) else $error("output not on fall");
    a_sect_align: assert property (req_valid_o && req_op_o == OP_ERASE_SECT |->
        req_addr_o[11:0] == 12'h000) else $error("sector base misaligned");
    a_b32_align: assert property (req_valid_o && req_op_o == OP_ERASE_B32 |->
        req_addr_o[14:0] == 15'h0000) else $error("32k base misaligned");
    a_b64_align: assert property (req_valid_o && req_op_o == OP_ERASE_B64 |->
        req_addr_o[15:0] == 16'h0000) else $error("64k base misaligned");
    a_cap_bound: assert property (req_valid_o |-> req_addr_o < CAP_BYTES)
        else $error("request beyond capacity");
    a_bp_locked: assert property (wp_held |=> $stable(block_protect_bits_o) && srp_o)
        else $error("protect bits changed while locked");
endmodule
bind sfs_spi_top sfs_spi_sva #(.CAP_BYTES(CAP_BYTES)) u_sva (.sys_clk_i, .resetn_i, .sclk_i,
    .cs_n_i, .wp_n_i, .dual_lane_one_o, .dual_lane_zero_oe_n_o, .dual_lane_one_oe_n_o,
    .req_valid_o, .req_op_o, .req_addr_o, .srp_o, .block_protect_bits_o);

// ==== sfs_host_model.sv ====
// host spi master model driving the serial pins
`timescale 1ns/1ps
module sfs_host_model (
    // reference clock
    input  wire logic clk_i,
    // pins towards the device
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      wp_n_o,
    output logic      lane0_o,
    // device lanes
    input  wire logic d0_i,
    input  wire logic oe0_n_i,
    input  wire logic d1_i,
    input  wire logic oe1_n_i
);
    logic cpol;
    logic hoe;
    logic mosi;
    // released lane shows inverse of last value
    assign lane0_o = !oe0_n_i ? d0_i : (hoe ? mosi : ~mosi);
    initial begin
        cpol = 1'b0;
        hoe = 1'b1;
        mosi = 1'b0;
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        wp_n_o = 1'b1;
    end
    task automatic start();
        @(negedge clk_i);
        sclk_o = cpol;
        #80 cs_n_o = 1'b0;
        #80;
    endtask
    task automatic stop();
        #80 sclk_o = cpol;
        #80 cs_n_o = 1'b1;
        hoe = 1'b1;
        #400;
    endtask
    task automatic xbyte(input logic [7:0] b, input bit dual, output logic [7:0] r);
        hoe = !dual;
        for (int i = 7; i >= 0; i -= (dual ? 2 : 1)) begin
            #80 sclk_o = 1'b0;
            mosi = b[i];
            #80 sclk_o = 1'b1;
            r[i] = oe1_n_i ? 1'bx : d1_i;
            if (dual) r[i-1] = lane0_o;
        end
    endtask
endmodule

// ==== tb_serial_flash_spi_interface.sv ====
// self-checking bench for the serial flash spi front end
`timescale 1ns/1ps
module tb_serial_flash_spi_interface import sfs_pkg::*;;
    logic        sys_clk_i, resetn_i, sclk_i, cs_n_i, wp_n_i, wip_i, req_ready_i;
    logic        dual_lane_zero_i, dual_lane_zero_o, dual_lane_zero_oe_n_o;
    logic        dual_lane_one_o, dual_lane_one_oe_n_o, req_valid_o;
    logic        wel_o, srp_o, overrun_o;
    logic [2:0]  block_protect_bits_o;
    logic [3:0]  req_op_o;
    logic [7:0]  rd_data_i, req_data_o, rx;
    logic [23:0] rd_addr_o, req_addr_o;
    int          err_count, checked;
    function automatic logic [7:0] fa(input logic [23:0] a);
        return a[7:0] ^ a[23:16] ^ 8'h5A;
    endfunction
    assign rd_data_i = fa(rd_addr_o);
    sfs_spi_top u_dut (.sys_clk_i, .resetn_i, .sclk_i, .cs_n_i, .wp_n_i, .dual_lane_zero_i,
        .dual_lane_zero_o, .dual_lane_zero_oe_n_o, .dual_lane_one_o, .dual_lane_one_oe_n_o,
        .rd_addr_o, .rd_data_i, .wip_i, .req_valid_o, .req_ready_i, .req_op_o, .req_addr_o,
        .req_data_o, .wel_o, .srp_o, .block_protect_bits_o, .overrun_o);
    sfs_host_model u_host (.clk_i(sys_clk_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
        .wp_n_o(wp_n_i), .lane0_o(dual_lane_zero_i), .d0_i(dual_lane_zero_o),
        .oe0_n_i(dual_lane_zero_oe_n_o), .d1_i(dual_lane_one_o), .oe1_n_i(dual_lane_one_oe_n_o));
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic op4(input logic [7:0] c, input logic [23:0] a);
        u_host.xbyte(c, 1'b0, rx);
        for (int i = 2; i >= 0; i--) u_host.xbyte(a[8*i+:8], 1'b0, rx);
    endtask
    task automatic frame2(input logic [7:0] c, input logic [7:0] d);
        u_host.start();
        u_host.xbyte(c, 1'b0, rx);
        u_host.xbyte(d, 1'b0, rx);
        u_host.stop();
    endtask
    task automatic wren();
        u_host.start();
        u_host.xbyte(CMD_WR_EN, 1'b0, rx);
        u_host.stop();
    endtask
    // waits for a request, checks it stands while stalled, then takes it
    task automatic get_req(input logic [39:0] e, input logic [39:0] m);
        int n;
        n = 0;
        while (req_valid_o !== 1'b1 && n < 200) begin
            @(negedge sys_clk_i);
            n++;
        end
        repeat (3) @(negedge sys_clk_i);
        chk("request", e, {3'h0, req_valid_o, req_op_o, req_addr_o, req_data_o} & m);
        req_ready_i = 1'b1;
        @(negedge sys_clk_i);
        req_ready_i = 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic t_read();
        for (int j = 0; j < 2; j++) begin
            u_host.start();
            op4(j ? CMD_RD_FAST : CMD_RD_DATA, 24'h01FFFF);
            if (j) u_host.xbyte(8'h00, 1'b0, rx);
            u_host.xbyte(8'h00, 1'b0, rx);
            chk("read first", fa(24'h01FFFF), rx);
            u_host.xbyte(8'h00, 1'b0, rx);
            chk("read wrap", {fa(24'h000000), 1'b1}, {rx, dual_lane_zero_oe_n_o});
            u_host.stop();
        end
    endtask
    task automatic t_dual();
        u_host.cpol = 1'b1;
        u_host.start();
        op4(CMD_RD_DUAL, 24'h000010);
        u_host.xbyte(8'h00, 1'b0, rx);
        for (int k = 0; k < 2; k++) begin
            u_host.xbyte(8'h00, 1'b1, rx);
            chk("dual byte", fa(24'h10 + 24'(k)), rx);
        end
        u_host.stop();
        u_host.cpol = 1'b0;
    endtask
    task automatic t_prog();
        wren();
        u_host.start();
        op4(CMD_PROG_PAGE, 24'h0120FE);
        for (int k = 0; k < 10; k++) u_host.xbyte(8'h10 + 8'(k), 1'b0, rx);
        u_host.stop();
        chk("overrun", 1'b1, overrun_o);
        for (int k = 0; k < 9; k++) begin
            get_req({4'h1, OP_PROG, 16'h0120, 8'hFE + 8'(k), 8'h10 + 8'(k)}, '1);
        end
        req_ready_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        req_ready_i = 1'b0;
        chk("wel after program", 1'b0, wel_o);
    endtask
    task automatic t_erase();
        logic [7:0]  c [4] = '{CMD_ERASE_SECT, CMD_ERASE_B32, CMD_ERASE_B64, CMD_ERASE_ALL};
        logic [3:0]  o [4] = '{OP_ERASE_SECT, OP_ERASE_B32, OP_ERASE_B64, OP_ERASE_ALL};
        logic [23:0] b [4] = '{24'h01F000, 24'h018000, 24'h010000, 24'h000000};
        for (int i = 0; i < 4; i++) begin
            wren();
            u_host.start();
            if (i < 3) op4(c[i], 24'h01F123);
            else u_host.xbyte(c[i], 1'b0, rx);
            u_host.stop();
            get_req({4'h1, o[i], b[i], 8'h00}, {8'hFF, {24{i < 3}}, 8'h00});
        end
    endtask
    task automatic t_protect();
        wip_i = 1'b1;
        wren();
        frame2(CMD_WR_STATUS, 8'h84);
        u_host.wp_n_o = 1'b0;
        wren();
        frame2(CMD_WR_STATUS, 8'h00);
        frame2(CMD_RD_STATUS, 8'h00);
        chk("status", 8'h85, rx);
        chk("protect bits", 4'h9, {srp_o, block_protect_bits_o});
        wren();
        u_host.start();
        op4(CMD_ERASE_SECT, 24'h000000);
        u_host.stop();
        repeat (10) @(negedge sys_clk_i);
        chk("protected erase", 1'b0, req_valid_o);
    endtask
    initial begin
        resetn_i = 1'b0;
        wip_i = 1'b0;
        req_ready_i = 1'b0;
        err_count = 0;
        checked = 0;
        repeat (2) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        chk("reset", 8'hC0, {dual_lane_zero_oe_n_o, dual_lane_one_oe_n_o, req_valid_o,
            wel_o, overrun_o, block_protect_bits_o});
        t_read();
        t_dual();
        t_prog();
        t_erase();
        t_protect();
        wrap_up();
    end
    initial begin
        #500000;
        err_count++;
        $display("BAD watchdog expected done seen hang");
        wrap_up();
    end
endmodule
